// ===== utxf_pkg.sv
package utxf_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [2:0] ADDR_CTRL1 = 3'h0;
  localparam logic [2:0] ADDR_CTRL2 = 3'h1;
  localparam logic [2:0] ADDR_CTRL3 = 3'h2;
  localparam logic [2:0] ADDR_STAT = 3'h3;
  localparam logic [2:0] ADDR_DATA = 3'h4;
  localparam logic [2:0] ADDR_BAUD = 3'h5;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  // control_reg_one
  localparam int C1_EN = 7;
  localparam int C1_WLEN = 6;
  localparam int C1_PEN = 5;
  localparam int C1_PTYPE = 4;
  localparam int C1_STOP2 = 3;
  localparam int C1_NINTH = 0;
  // control_reg_two
  localparam int C2_TRANSMIT_ENABLE = 7;
  localparam int C2_RECEIVE_ENABLE = 6;
  localparam int C2_BRK = 5;
  localparam int C2_HSPD = 4;
  localparam int C2_ADDR = 3;
  localparam int C2_EMPTY_INTERRUPT_ENABLE = 0;
  // status_register
  localparam int S_TRANSMITTER_IDLE_FLAG = 5;
  localparam int S_TXE = 4;
  localparam int S_RECEIVER_IDLE_FLAG = 3;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [7:0] CTRL1_RST = 8'h00;  // 8 data, no parity, 1 stop
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [5:0] PRE_LO = 6'h3F;     // 64 clocks per unit
  localparam logic [5:0] PRE_HI = 6'h0F;     // 16 clocks per unit
  localparam logic [3:0] NBITS8 = 4'h8;
  localparam logic [3:0] NBITS9 = 4'h9;

  typedef enum logic [2:0] {
    UTXF_IDLE, UTXF_START, UTXF_DATA, UTXF_PAR, UTXF_STOP1, UTXF_STOP2
  } utxf_state_t;

  // Format bits gathered from control_reg_one
  typedef struct packed {
    logic nine;
    logic par_en;
    logic par_odd;
    logic two_stop;
  } utxf_fmt_t;
endpackage

// ===== utxf_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Frame: start, 8 or 9 data, stop_bit_count_select
// - Parity even/odd/none; reset format 8N1
// - Shared 8-bit baud generator, LSB first
// - Enabled pins act serial, line idles high
// - Disable releases pins, empties data buffer
// - Disable clears/sets listed flags, keeps rest
// - Disable aborts at once; re-enable keeps config
// - Select bits choose length, parity, stop_bit_count_select
// - Address detect: MSB marks address frame
// - Two stop_bit_count_select only for transmitter
// - Ninth bit comes from ninth_transmit_bit
// - Shifter reloads only after stop sent
// - Start needs enable, data and baud tick
// - Clearing transmit_enable resets transmitter
// - Data writes blocked while empty flag low
// - Empty flag clears: status access, data write
// - Empty flag set when buffer free; irq
// - Idle write loads shifter, sets empty flag
// - Idle flag set at frame end, same clear
// - Rate = clk / (64 or 16 * (N+1))
module utxf_top (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic tx_o,
  output logic tx_oe_n,
  output logic rx_pin_en,
  output logic irq_empty
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [7:0] baud_q;
  logic [7:0] buf_q;
  logic buf_full_q;
  logic txe_q;
  logic transmitter_idle_flag_q;
  logic stat_seen_q;
  logic [8:0] shift_q;
  logic par_q;
  logic [3:0] bit_cnt_q;
  utxf_pkg::utxf_state_t st_q;
  logic [5:0] pre_q;
  logic [7:0] div_q;
  logic tick;
  logic en;
  logic transmit_enable;
  logic busy;
  logic dwr;
  logic dwr_ok;
  logic load_buf;
  logic load_direct;
  logic frame_end;
  utxf_pkg::utxf_fmt_t fmt;

  assign en = ctrl1_q[utxf_pkg::C1_EN];
  assign transmit_enable = ctrl2_q[utxf_pkg::C2_TRANSMIT_ENABLE];
  assign fmt.nine = ctrl1_q[utxf_pkg::C1_WLEN];
  assign fmt.par_en = ctrl1_q[utxf_pkg::C1_PEN];
  assign fmt.par_odd = ctrl1_q[utxf_pkg::C1_PTYPE];
  assign fmt.two_stop = ctrl1_q[utxf_pkg::C1_STOP2];
  assign busy = (st_q != utxf_pkg::UTXF_IDLE);
  assign dwr = reg_wr && (reg_addr == utxf_pkg::ADDR_DATA);
  // Writes land only when the empty flag is set and the unit is on
  assign dwr_ok = dwr && en && txe_q;
  // Idle shifter takes a write straight away, without buffering
  assign load_direct = dwr_ok && transmit_enable && !busy && !buf_full_q;
  assign load_buf = buf_full_q && transmit_enable && !busy;

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Disable clears only the listed control bits; format and divisor survive
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl1_q <= utxf_pkg::CTRL1_RST;
      ctrl2_q <= utxf_pkg::CTRL2_RST;
      baud_q <= utxf_pkg::BAUD_RST;
    end else begin
      if (reg_wr && reg_addr == utxf_pkg::ADDR_CTRL1) begin
        ctrl1_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == utxf_pkg::ADDR_BAUD) begin
        baud_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == utxf_pkg::ADDR_CTRL2) begin
        ctrl2_q <= reg_wdata;
      end
      if (!en || (reg_wr && reg_addr == utxf_pkg::ADDR_CTRL1 && !reg_wdata[utxf_pkg::C1_EN])) begin
        ctrl2_q[utxf_pkg::C2_TRANSMIT_ENABLE] <= 1'b0;
        ctrl2_q[utxf_pkg::C2_RECEIVE_ENABLE] <= 1'b0;
        ctrl2_q[utxf_pkg::C2_BRK] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Baud generator
  // ****************************************************************
  // One tick per bit: prescale 64 or 16 times (N+1); free running
  always_ff @(posedge sys_clk) begin
    if (srst || !en) begin
      pre_q <= '0;
      div_q <= '0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if ((ctrl2_q[utxf_pkg::C2_HSPD] && pre_q >= utxf_pkg::PRE_HI)
          || pre_q == utxf_pkg::PRE_LO) begin
        pre_q <= '0;
        if (div_q >= baud_q) begin
          div_q <= '0;
          tick <= 1'b1;
        end else begin
          div_q <= div_q + 8'h01;
        end
      end else begin
        pre_q <= pre_q + 6'h01;
      end
    end
  end

  // ****************************************************************
  // Data buffer and flags
  // ****************************************************************
  // Status read arms the clear; the data write completes it
  always_ff @(posedge sys_clk) begin
    if (srst || !en) begin
      stat_seen_q <= 1'b0;
    end else if (reg_rd && reg_addr == utxf_pkg::ADDR_STAT) begin
      stat_seen_q <= 1'b1;
    end else if (dwr) begin
      stat_seen_q <= 1'b0;
    end
  end

  // A frame ends at the tick that closes its last stop bit, not the one that opens it
  assign frame_end = tick && ((st_q == utxf_pkg::UTXF_PAR && !fmt.two_stop)
                              || st_q == utxf_pkg::UTXF_STOP2);

  // Disable empties the buffer and forces both flags set
  always_ff @(posedge sys_clk) begin
    if (srst || !en) begin
      buf_q <= '0;
      buf_full_q <= 1'b0;
      txe_q <= 1'b1;
      transmitter_idle_flag_q <= 1'b1;
    end else begin
      if (dwr_ok && !load_direct) begin
        buf_q <= reg_wdata;
        buf_full_q <= 1'b1;
      end else if (load_buf) begin
        // A byte written before transmit_enable waits here until it is set
        buf_full_q <= 1'b0;
      end
      // Clear needs the status access first; set wins over the clear
      if (load_direct || load_buf) begin
        txe_q <= 1'b1;
      end else if (dwr_ok && stat_seen_q) begin
        txe_q <= 1'b0;
      end
      // An aborted frame also leaves the transmitter idle
      if (frame_end || (!transmit_enable && busy)) begin
        transmitter_idle_flag_q <= 1'b1;
      end else if (dwr_ok && stat_seen_q) begin
        transmitter_idle_flag_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Transmit shifter
  // ****************************************************************
  // Frame runs on baud ticks; transmit_enable low aborts immediately
  always_ff @(posedge sys_clk) begin
    if (srst || !en || !transmit_enable) begin
      st_q <= utxf_pkg::UTXF_IDLE;
      shift_q <= '0;
      par_q <= 1'b0;
      bit_cnt_q <= '0;
      tx_o <= 1'b1;
    end else begin
      if (load_direct || load_buf) begin
        // Ninth bit from the control register; MSB is address mark
        shift_q <= {ctrl1_q[utxf_pkg::C1_NINTH],
                    load_direct ? reg_wdata : buf_q};
        st_q <= utxf_pkg::UTXF_START;
        tx_o <= 1'b1;
      end else if (tick) begin
        case (st_q)
          utxf_pkg::UTXF_START: begin
            tx_o <= 1'b0;
            par_q <= fmt.par_odd;
            bit_cnt_q <= fmt.nine ? utxf_pkg::NBITS9 : utxf_pkg::NBITS8;
            st_q <= utxf_pkg::UTXF_DATA;
          end
          utxf_pkg::UTXF_DATA: begin
            // Last data slot carries parity when enabled
            if (fmt.par_en && bit_cnt_q == 4'h1) begin
              tx_o <= par_q;
              st_q <= utxf_pkg::UTXF_STOP1;
            end else begin
              tx_o <= shift_q[0];
              par_q <= par_q ^ shift_q[0];
              shift_q <= {1'b0, shift_q[8:1]};
              if (bit_cnt_q == 4'h1) begin
                st_q <= utxf_pkg::UTXF_STOP1;
              end
            end
            bit_cnt_q <= bit_cnt_q - 4'h1;
          end
          utxf_pkg::UTXF_STOP1: begin
            tx_o <= 1'b1;
            st_q <= utxf_pkg::UTXF_PAR;
          end
          utxf_pkg::UTXF_PAR: begin
            // Second stop or frame end; reload waits until the frame end
            tx_o <= 1'b1;
            st_q <= fmt.two_stop ? utxf_pkg::UTXF_STOP2 : utxf_pkg::UTXF_IDLE;
          end
          utxf_pkg::UTXF_STOP2: begin
            tx_o <= 1'b1;
            st_q <= utxf_pkg::UTXF_IDLE;
          end
          default: begin
            tx_o <= 1'b1;
            st_q <= utxf_pkg::UTXF_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Pins, interrupt and read data
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_oe_n <= 1'b1;
      rx_pin_en <= 1'b0;
      irq_empty <= 1'b0;
      reg_rdata <= '0;
    end else begin
      tx_oe_n <= !(en && transmit_enable);
      rx_pin_en <= en && ctrl2_q[utxf_pkg::C2_RECEIVE_ENABLE];
      irq_empty <= txe_q && ctrl2_q[utxf_pkg::C2_EMPTY_INTERRUPT_ENABLE];
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          utxf_pkg::ADDR_CTRL1: reg_rdata <= ctrl1_q;
          utxf_pkg::ADDR_CTRL2: reg_rdata <= ctrl2_q;
          utxf_pkg::ADDR_BAUD: reg_rdata <= baud_q;
          utxf_pkg::ADDR_DATA: reg_rdata <= buf_q;
          utxf_pkg::ADDR_STAT: begin
            reg_rdata[utxf_pkg::S_TRANSMITTER_IDLE_FLAG] <= transmitter_idle_flag_q;
            reg_rdata[utxf_pkg::S_TXE] <= txe_q;
            reg_rdata[utxf_pkg::S_RECEIVER_IDLE_FLAG] <= 1'b1;
          end
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_idle_high;
    @(posedge sys_clk) disable iff (srst) (st_q == utxf_pkg::UTXF_IDLE) |=> tx_o;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not high when idle");

  property p_dis_flags;
    @(posedge sys_clk) disable iff (srst) !en |=> txe_q && transmitter_idle_flag_q && !buf_full_q;
  endproperty
  a_dis_flags: assert property (p_dis_flags) else $error("disable flags wrong");

  property p_dis_transmit_enable;
    @(posedge sys_clk) disable iff (srst) !en |=> !ctrl2_q[utxf_pkg::C2_TRANSMIT_ENABLE];
  endproperty
  a_dis_transmit_enable: assert property (p_dis_transmit_enable) else $error("transmit_enable kept on disable");

  property p_abort;
    @(posedge sys_clk) disable iff (srst) (!en || !transmit_enable) |=> st_q == utxf_pkg::UTXF_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("frame not aborted");

  property p_block;
    @(posedge sys_clk) disable iff (srst) (!txe_q && dwr && en) |=> $stable(buf_q);
  endproperty
  a_block: assert property (p_block) else $error("write not blocked");

  property p_clear_seq;
    @(posedge sys_clk) disable iff (srst) $fell(txe_q) |-> $past(dwr) && $past(stat_seen_q);
  endproperty
  a_clear_seq: assert property (p_clear_seq) else $error("empty cleared out of order");

  property p_start_bit;
    @(posedge sys_clk) disable iff (srst) (st_q == utxf_pkg::UTXF_START && tick && transmit_enable && en)
      |=> !tx_o;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("no start bit");

  property p_no_reload;
    @(posedge sys_clk) disable iff (srst)
      (st_q != utxf_pkg::UTXF_IDLE && st_q != utxf_pkg::UTXF_START)
      |=> st_q != utxf_pkg::UTXF_START;
  endproperty
  a_no_reload: assert property (p_no_reload) else $error("reload during frame");

  property p_idle_set;
    @(posedge sys_clk) disable iff (srst) frame_end |=> transmitter_idle_flag_q;
  endproperty
  a_idle_set: assert property (p_idle_set) else $error("idle flag not set");

  c_direct: cover property (@(posedge sys_clk) disable iff (srst) load_direct);
  c_buffered: cover property (@(posedge sys_clk) disable iff (srst) load_buf);
  c_frame: cover property (@(posedge sys_clk) disable iff (srst) frame_end);
  c_parity: cover property (@(posedge sys_clk) disable iff (srst) frame_end && fmt.par_en);
  c_two_stop: cover property (@(posedge sys_clk) disable iff (srst) frame_end && fmt.two_stop);

  // ****************************************************************
  // Bit period checker
  // ****************************************************************
  // Cycles since the last tick; a rate change skips the next tick,
  // since a part-done period mixes the old and the new rate
  logic [15:0] gap_q;
  logic cfg_chg_q;
  always_ff @(posedge sys_clk) begin
    if (srst || !en || tick) begin
      gap_q <= '0;
    end else begin
      gap_q <= gap_q + 16'h0001;
    end
  end

  // Marks a period whose length is not that of the current setup
  always_ff @(posedge sys_clk) begin
    if (srst || !en || (reg_wr && (reg_addr == utxf_pkg::ADDR_BAUD
                                   || reg_addr == utxf_pkg::ADDR_CTRL2))) begin
      cfg_chg_q <= 1'b1;
    end else if (tick) begin
      cfg_chg_q <= 1'b0;
    end
  end

  property p_bit_period;
    @(posedge sys_clk) disable iff (srst) (tick && !cfg_chg_q)
      |-> gap_q + 16'h0001 == ({10'h000, (ctrl2_q[utxf_pkg::C2_HSPD] ? utxf_pkg::PRE_HI
          : utxf_pkg::PRE_LO)} + 16'h0001) * ({8'h00, baud_q} + 16'h0001);
  endproperty
  a_bit_period: assert property (p_bit_period) else $error("bit period wrong");

  property p_oe_on;
    @(posedge sys_clk) disable iff (srst) (en && transmit_enable) |=> !tx_oe_n;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("tx pin not claimed");

  property p_pins_free;
    @(posedge sys_clk) disable iff (srst) !en |=> tx_oe_n && !rx_pin_en;
  endproperty
  a_pins_free: assert property (p_pins_free) else $error("pins kept on disable");

  property p_stop_high;
    @(posedge sys_clk) disable iff (srst) (st_q == utxf_pkg::UTXF_STOP1 && tick) |=> tx_o;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit not high");

  property p_ninth;
    @(posedge sys_clk) disable iff (srst) load_direct
      |=> shift_q == {$past(ctrl1_q[utxf_pkg::C1_NINTH]), $past(reg_wdata)};
  endproperty
  a_ninth: assert property (p_ninth) else $error("shifter load wrong");

  property p_direct_empty;
    @(posedge sys_clk) disable iff (srst) load_direct |=> txe_q && st_q == utxf_pkg::UTXF_START;
  endproperty
  a_direct_empty: assert property (p_direct_empty) else $error("direct load flag wrong");

  property p_cfg_kept;
    @(posedge sys_clk) disable iff (srst) (!en && !reg_wr) |=> $stable(ctrl1_q) && $stable(baud_q);
  endproperty
  a_cfg_kept: assert property (p_cfg_kept) else $error("setup lost while off");
endmodule // utxf_top

// ===== utxf_line_model.sv
`timescale 1ns/1ps
// Remote receiver on the serial line; it sees only the resolved wire level
module utxf_line_model (
  input wire logic sys_clk,
  input wire logic line,
  input wire logic [7:0] bit_clks,
  input wire logic [3:0] n_bits,
  output logic [10:0] word,
  output int count
);
  logic [10:0] w;
  // ************************************************************
  // Frame capture
  // ************************************************************
  // Start edge, then mid-bit samples one bit period apart
  initial begin
    word = '1;
    count = 0;
    forever begin
      @(negedge line);
      repeat (bit_clks / 2) @(posedge sys_clk);
      // A glitch shorter than half a bit is not a start bit
      if (line === 1'b0) begin
        w = '1;
        for (int i = 0; i < n_bits; i++) begin
          repeat (bit_clks) @(posedge sys_clk);
          w[i] = line;
        end
        word = w;
        count++;
      end
    end
  end
endmodule // utxf_line_model

// ===== utxf_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module utxf_tb_top;
  logic sys_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, v, bit_clks = 8'h10;
  logic tx_o, tx_oe_n, rx_pin_en, irq_empty;
  logic [3:0] n_bits = 4'hA;
  logic [10:0] m_word;
  int m_cnt, n_fail = 0, comparisons = 0, cyc = 0, k;
  wire line = tx_oe_n ? 1'b1 : tx_o; // Pull-up once released
  // Rows: ctrl1, ctrl2, baud, first and second data
  logic [39:0] rows [5] = '{40'h80_90_00_A5_3C, 40'hC1_90_00_5A_FF, 40'hA0_90_01_13_F1,
                            40'hB8_80_00_6E_01, 40'hE0_91_00_C3_7F};
  utxf_top u_dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_o(tx_o), .tx_oe_n(tx_oe_n),
    .rx_pin_en(rx_pin_en), .irq_empty(irq_empty));
  utxf_line_model u_peer (.sys_clk(sys_clk), .line(line), .bit_clks(bit_clks),
    .n_bits(n_bits), .word(m_word), .count(m_cnt));
  // ************************************************************
  // Clock, watchdog and bus tasks
  // ************************************************************
  initial forever #20 sys_clk = ~sys_clk;
  // Cuts a hang; the whole run needs far fewer cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Status access before the data write, or the write does not clear the empty flag
  task automatic send(input logic [7:0] d);
    rd(utxf_pkg::ADDR_STAT, v);
    wr(utxf_pkg::ADDR_DATA, d);
  endtask
  // Expected line bits after the start bit
  function automatic logic [10:0] exp_frame(input logic [7:0] c1, input logic [7:0] d);
    logic [10:0] f;
    logic p;
    int n;
    n = c1[utxf_pkg::C1_WLEN] ? 9 : 8;
    f = {2'b11, c1[utxf_pkg::C1_NINTH], d};
    if (!c1[utxf_pkg::C1_WLEN]) f[8] = 1'b1;
    p = c1[utxf_pkg::C1_PTYPE];
    for (int i = 0; i < n - 1; i++) p ^= f[i];
    if (c1[utxf_pkg::C1_PEN]) f[n - 1] = p;
    return f;
  endfunction
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    #1;
    `CHK({tx_o, tx_oe_n, irq_empty}, 3'b110)
    rd(utxf_pkg::ADDR_CTRL1, v);
    `CHK(v, 8'h00)
    rd(3'h7, v);
    `CHK(v, 8'h00)
    // Two frames back to back, then a write that must be ignored
    foreach (rows[r]) begin
      wr(utxf_pkg::ADDR_CTRL1, rows[r][39:32]);
      wr(utxf_pkg::ADDR_BAUD, rows[r][23:16]);
      wr(utxf_pkg::ADDR_CTRL2, rows[r][31:24]);
      bit_clks <= (rows[r][28] ? 8'h10 : 8'h40) * (rows[r][23:16] + 8'h01);
      n_bits <= (rows[r][38] ? 4'h9 : 4'h8) + (rows[r][35] ? 4'h2 : 4'h1);
      k = m_cnt;
      send(rows[r][15:8]);
      send(rows[r][7:0]);
      send(8'h00);
      #1 `CHK(tx_oe_n, 1'b0)
      wait (m_cnt == k + 1);
      `CHK(m_word, exp_frame(rows[r][39:32], rows[r][15:8]))
      wait (m_cnt == k + 2);
      `CHK(m_word, exp_frame(rows[r][39:32], rows[r][7:0]))
      repeat (13 * bit_clks) @(posedge sys_clk);
      `CHK(m_cnt, k + 2)
      rd(utxf_pkg::ADDR_STAT, v);
      `CHK(v & 8'h30, 8'h30)
      `CHK(irq_empty, rows[r][24])
    end
    // Disable in mid-frame with a byte waiting; that byte must be lost
    wr(utxf_pkg::ADDR_CTRL2, 8'hD1);
    send(8'h81);
    send(8'h7E);
    repeat (64) @(posedge sys_clk);
    `CHK(rx_pin_en, 1'b1)
    wr(utxf_pkg::ADDR_CTRL1, 8'h60);
    // Pin outputs are registered, so they follow one edge after the write
    @(posedge sys_clk);
    #1 `CHK({tx_oe_n, line, rx_pin_en}, 3'b110)
    rd(utxf_pkg::ADDR_CTRL2, v);
    `CHK(v, 8'h11)
    rd(utxf_pkg::ADDR_CTRL1, v);
    `CHK(v, 8'h60)
    rd(utxf_pkg::ADDR_STAT, v);
    `CHK(v & 8'h30, 8'h30)
    repeat (200) @(posedge sys_clk);
    k = m_cnt;
    wr(utxf_pkg::ADDR_CTRL1, 8'hE0);
    wr(utxf_pkg::ADDR_CTRL2, 8'h91);
    send(8'h42);
    wait (m_cnt == k + 1);
    `CHK(m_word, exp_frame(8'hE0, 8'h42))
    // A byte written while transmit_enable is off goes out once it is set
    wr(utxf_pkg::ADDR_CTRL2, 8'h11);
    k = m_cnt;
    send(8'h99);
    rd(utxf_pkg::ADDR_STAT, v);
    `CHK(v & 8'h10, 8'h00)
    wr(utxf_pkg::ADDR_CTRL2, 8'h91);
    wait (m_cnt == k + 1);
    `CHK(m_word, exp_frame(8'hE0, 8'h99))
    repeat (20) @(posedge sys_clk);
    stop_test();
  end
endmodule // utxf_tb_top
